/* common/dsl_pkg.sv */
/*
 * Shared constants and carrier types for the drive diagnostic and status logger:
 * register map, field positions, self-test codes, fault bits, unit codes, timing.
 * Assumes a 200 MHz bus clock and a word-wide AHB-Lite register port.
 */
`default_nettype none
package dsl_pkg;
    // Register byte offsets
    localparam logic [7:0] ADDR_POST_RESULT = 8'h00; // Self-test outcome, written by firmware
    localparam logic [7:0] ADDR_STATUS_PUSH = 8'h04; // Appends a status code to the status log
    localparam logic [7:0] ADDR_FAULT_PUSH  = 8'h08; // Appends a fault code to the fault log
    localparam logic [7:0] ADDR_STATE       = 8'h0c; // Live state, read only
    localparam logic [7:0] ADDR_UNITS       = 8'h10; // Ranked replaceable units, read only
    // Field layout
    localparam int         POST_FAIL_W      = 6;     // One failure flag per self-test
    localparam int         POST_PANEL_BIT   = 8;     // Panel exchange failed
    localparam logic [1:0] HTRANS_NONSEQ    = 2'h2;
    localparam logic [2:0] HSIZE_WORD       = 3'h2;
    // Self-test failure codes, flag index order 0..5
    localparam logic [3:0] FAIL_CODE [POST_FAIL_W] = '{4'hf, 4'he, 4'hd, 4'hc, 4'hb, 4'ha};
    // Fault bit positions
    localparam int FLT_READ_WRITING = 0;
    localparam int FLT_OFF_CYL      = 1;
    localparam int FLT_FIRST_SEEK   = 2;
    localparam int FLT_WRITE        = 3;
    localparam int FLT_WRITE_PROT   = 4;
    localparam int FLT_HEAD_SEL     = 5;
    localparam int FLT_VOLTAGE      = 6;
    localparam int FLT_UNUSED       = 7;
    // Replaceable unit codes
    localparam logic [7:0] UNIT_CTRL_A   = 8'h01;
    localparam logic [7:0] UNIT_MODULE_A = 8'h02;
    localparam logic [7:0] UNIT_PSU      = 8'h03;
    localparam logic [7:0] UNIT_IO       = 8'h04;
    localparam logic [7:0] UNIT_CTRL_B   = 8'h05;
    localparam logic [7:0] UNIT_MODULE_B = 8'h06;
    // Test numbers with hardware behaviour
    localparam logic [7:0] TEST_STATUS_LOG = 8'h00;
    localparam logic [7:0] TEST_FAULT_LOG  = 8'h01;
    localparam logic [7:0] TEST_UNITS      = 8'h04;
    // Timing
    localparam int POST_TIME_MS = 4000;
    localparam int CLK_MHZ      = 200;
    localparam int POST_CYCLES  = POST_TIME_MS * 1000 * CLK_MHZ;
    localparam int LOG_DEPTH    = 8;

    typedef enum logic [1:0] {POST_RUN, POST_PASS, POST_FAIL} dsl_post_t;
    typedef enum logic [1:0] {DIAG_OFF, DIAG_SELECT, DIAG_RUN} dsl_diag_t;
    typedef enum logic [2:0] {VIEW_STATUS, VIEW_PANEL_FAIL, VIEW_SELECT, VIEW_STATUS_LOG,
                              VIEW_FAULT_LOG, VIEW_UNITS, VIEW_TEST_BUSY} dsl_view_t;
    // Front panel lamps
    typedef struct packed {
        logic [3:0] addr;   // Weighted 8-4-2-1
        logic       ready;
        logic       fault;
        logic       wprot;
    } dsl_lamps_t;
    // Panel display content
    typedef struct packed {
        dsl_view_t  view;
        logic       newest; // Asterisk before slot
        logic [2:0] slot;
        logic [7:0] code;   // Log code or selected test
        logic [7:0] unit0;  // Most likely
        logic [7:0] unit1;
        logic [7:0] unit2;
    } dsl_disp_t;
    // Synchronised keypad pins
    typedef struct packed {
        logic       mode;
        logic       run;
        logic       step;
        logic       hex_stb;
        logic [3:0] hex;
    } dsl_keys_t;
endpackage
`default_nettype wire

/* rtl/dsl_top.sv */
/*
 * Drive diagnostic and status logger: power-up lamp sequencing, two eight-slot
 * logs, maintenance-mode test selection and replaceable-unit ranking.
 * Assumes keypad pins are asynchronous and held for several clocks per press,
 * and that firmware reports self-test outcomes and log codes over AHB-Lite.
 */
// Function
// - All lamps lit while self-tests run
// - Fault lamp off about four seconds on pass
// - Ready and fault lamps held on failure
// - Address lamps show failing test code
// - Codes F,E,D,C,B,A per test order
// - Panel exchange failure shows panel message
// - Mode key toggles diagnostics, cuts host I/O; enters only after self-test pass
// - Run during test returns to selection
// - Keep eight newest status codes
// - Show slot, colon, two-digit code
// - Asterisk marks newest entry slot
// - Step key advances displayed slot
// - Separate eight-entry fault log, same display
// - Simultaneous faults share one stored code
// - Fault bits zero to three defined
// - Fault bits four to six defined, seven clear
// - Three units ranked from log history
// - Unit code values per replaceable unit
`timescale 1ns/1ps
`default_nettype none
module dsl_top #(
    parameter int unsigned POST_CYCLES = dsl_pkg::POST_CYCLES // Self-test lamp period
) (
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic                   hresp,
    output logic [31:0]            hrdata,
    input  wire dsl_pkg::dsl_keys_t keys_pin,
    output dsl_pkg::dsl_lamps_t    lamps,
    output dsl_pkg::dsl_disp_t     disp,
    output logic                   host_io_en
);
    // Keypad synchroniser stages and press detector
    dsl_pkg::dsl_keys_t keys_meta, keys_sync, keys_prev;
    dsl_pkg::dsl_keys_t press;          // One-cycle rising edges; hex is the synchronised level

    // Two flops before any logic; only keys_sync and keys_prev are looked at
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            keys_meta <= '0;
            keys_sync <= '0;
            keys_prev <= '0;
        end
        else
        begin
            keys_meta <= keys_pin;
            keys_sync <= keys_meta;
            keys_prev <= keys_sync;
        end
    end

    // Edge detect on the synchronised copy
    always_comb
    begin
        press     = keys_sync & ~keys_prev;
        press.hex = keys_sync.hex;
    end

    // Bus slave state
    logic       wr_pend, next_wr_pend;      // Write data phase due
    logic [7:0] wr_addr, next_wr_addr;
    logic [31:0] next_hrdata;
    logic       accept;
    logic       status_push, fault_push, post_wr;

    // Post sequencing state
    dsl_pkg::dsl_post_t post, next_post;
    logic [31:0] post_cnt, next_post_cnt;
    logic [dsl_pkg::POST_FAIL_W-1:0] fail_flags, next_fail_flags;
    logic       panel_fail, next_panel_fail;
    logic [3:0] fail_code;

    // Diagnostic state
    dsl_pkg::dsl_diag_t diag, next_diag;
    logic [7:0] test_sel, next_test_sel;    // Last two hex digits
    logic [1:0] digits, next_digits;        // Digits entered, saturates at 2
    logic [7:0] test_run, next_test_run;
    logic [2:0] view_slot, next_view_slot;
    logic [7:0] unit0, unit1, unit2, next_unit0, next_unit1, next_unit2;

    // Logs
    logic [7:0] status_log [dsl_pkg::LOG_DEPTH];
    logic [7:0] fault_log  [dsl_pkg::LOG_DEPTH];
    logic [2:0] status_wp, fault_wp, next_status_wp, next_fault_wp;
    logic [7:0] fault_or;                   // Union of the fault history
    logic       status_seen;                // Any nonzero status in history

    dsl_pkg::dsl_lamps_t next_lamps;
    dsl_pkg::dsl_disp_t  next_disp;

    // Zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign accept    = hsel && hready && (htrans == dsl_pkg::HTRANS_NONSEQ)
                       && (hsize == dsl_pkg::HSIZE_WORD);
    assign post_wr     = wr_pend && (wr_addr == dsl_pkg::ADDR_POST_RESULT);
    assign status_push = wr_pend && (wr_addr == dsl_pkg::ADDR_STATUS_PUSH);
    assign fault_push  = wr_pend && (wr_addr == dsl_pkg::ADDR_FAULT_PUSH);

    // Address phase decode; read data is ready for the data phase
    always_comb
    begin
        next_wr_pend = accept && hwrite;
        next_wr_addr = haddr[7:0];
        next_hrdata  = hrdata;
        if (accept && !hwrite)
        begin
            case (haddr[7:0])
                dsl_pkg::ADDR_POST_RESULT: next_hrdata = {23'h0, panel_fail, 2'h0, fail_flags};
                // Exactly one word: test number in the top byte, flags packed below
                dsl_pkg::ADDR_STATE:       next_hrdata = {test_run, 5'h0, view_slot, 4'h0,
                                                          fail_code, 4'h0, diag, post};
                dsl_pkg::ADDR_UNITS:       next_hrdata = {8'h0, unit0, unit1, unit2};
                default:                   next_hrdata = 32'h0; // Push and unmapped read zero
            endcase
        end
        else if (accept)
            next_hrdata = 32'h0;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h0;
            hrdata  <= 32'h0;
        end
        else
        begin
            wr_pend <= next_wr_pend;
            wr_addr <= next_wr_addr;
            hrdata  <= next_hrdata;
        end
    end

    // First failing test in order wins the lamps
    always_comb
    begin
        fail_code = 4'h0;
        for (int i = dsl_pkg::POST_FAIL_W - 1; i >= 0; i--)
            if (fail_flags[i])
                fail_code = dsl_pkg::FAIL_CODE[i];
    end

    // Self-test period; firmware may report results any time before it ends
    always_comb
    begin
        next_post       = post;
        next_post_cnt   = post_cnt;
        next_fail_flags = fail_flags;
        next_panel_fail = panel_fail;
        if (post_wr && post == dsl_pkg::POST_RUN)
        begin
            next_fail_flags = hwdata[dsl_pkg::POST_FAIL_W-1:0];
            next_panel_fail = hwdata[dsl_pkg::POST_PANEL_BIT];
        end
        if (post == dsl_pkg::POST_RUN)
        begin
            if (post_cnt >= POST_CYCLES - 1)
                next_post = (next_fail_flags != '0) ? dsl_pkg::POST_FAIL : dsl_pkg::POST_PASS;
            else
                next_post_cnt = post_cnt + 32'h1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            post       <= dsl_pkg::POST_RUN;
            post_cnt   <= 32'h0;
            fail_flags <= '0;
            panel_fail <= 1'b0;
        end
        else
        begin
            post       <= next_post;
            post_cnt   <= next_post_cnt;
            fail_flags <= next_fail_flags;
            panel_fail <= next_panel_fail;
        end
    end

    // History summary for unit ranking
    always_comb
    begin
        fault_or    = 8'h0;
        status_seen = 1'b0;
        for (int i = 0; i < dsl_pkg::LOG_DEPTH; i++)
        begin
            fault_or    = fault_or | fault_log[i];
            status_seen = status_seen | (status_log[i] != 8'h0);
        end
    end

    // Maintenance mode, test selection and unit ranking
    always_comb
    begin
        next_diag      = diag;
        next_test_sel  = test_sel;
        next_digits    = digits;
        next_test_run  = test_run;
        next_view_slot = view_slot;
        next_unit0     = unit0;
        next_unit1     = unit1;
        next_unit2     = unit2;
        case (diag)
            dsl_pkg::DIAG_OFF:
            begin
                // Only a drive that passed power-up enters diagnostics
                if (press.mode && post == dsl_pkg::POST_PASS)
                begin
                    next_diag   = dsl_pkg::DIAG_SELECT;
                    next_digits = 2'h0;
                end
            end
            dsl_pkg::DIAG_SELECT:
            begin
                if (press.mode)
                    next_diag = dsl_pkg::DIAG_OFF;
                else if (press.hex_stb)
                begin
                    // Extra digits shift the older one out
                    next_test_sel = {test_sel[3:0], press.hex};
                    next_digits   = (digits == 2'h2) ? digits : digits + 2'h1;
                end
                else if (press.run && digits == 2'h2)
                begin
                    next_diag      = dsl_pkg::DIAG_RUN;
                    next_test_run  = test_sel;
                    next_view_slot = 3'h0;
                    // Ranked once at start so the answer is stable while shown
                    if (fault_or[dsl_pkg::FLT_VOLTAGE])
                        {next_unit0, next_unit1, next_unit2} =
                            {dsl_pkg::UNIT_PSU, dsl_pkg::UNIT_CTRL_A, dsl_pkg::UNIT_MODULE_A};
                    else if (fault_or[dsl_pkg::FLT_READ_WRITING] || fault_or[dsl_pkg::FLT_WRITE]
                             || fault_or[dsl_pkg::FLT_HEAD_SEL])
                        {next_unit0, next_unit1, next_unit2} =
                            {dsl_pkg::UNIT_MODULE_A, dsl_pkg::UNIT_CTRL_A, dsl_pkg::UNIT_MODULE_B};
                    else if (fault_or[dsl_pkg::FLT_OFF_CYL] || fault_or[dsl_pkg::FLT_FIRST_SEEK])
                        {next_unit0, next_unit1, next_unit2} =
                            {dsl_pkg::UNIT_CTRL_A, dsl_pkg::UNIT_MODULE_A, dsl_pkg::UNIT_CTRL_B};
                    else if (fault_or[dsl_pkg::FLT_WRITE_PROT] || status_seen)
                        {next_unit0, next_unit1, next_unit2} =
                            {dsl_pkg::UNIT_IO, dsl_pkg::UNIT_CTRL_A, dsl_pkg::UNIT_MODULE_A};
                    else
                        {next_unit0, next_unit1, next_unit2} =
                            {dsl_pkg::UNIT_CTRL_A, dsl_pkg::UNIT_IO, dsl_pkg::UNIT_PSU};
                end
            end
            dsl_pkg::DIAG_RUN:
            begin
                if (press.mode)
                    next_diag = dsl_pkg::DIAG_OFF;
                else if (press.run)
                begin
                    next_diag   = dsl_pkg::DIAG_SELECT;
                    next_digits = 2'h0;
                end
                else if (press.step)
                    next_view_slot = view_slot + 3'h1;
            end
            default: next_diag = dsl_pkg::DIAG_OFF;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            diag      <= dsl_pkg::DIAG_OFF;
            test_sel  <= 8'h0;
            digits    <= 2'h0;
            test_run  <= 8'h0;
            view_slot <= 3'h0;
            unit0     <= 8'h0;
            unit1     <= 8'h0;
            unit2     <= 8'h0;
        end
        else
        begin
            diag      <= next_diag;
            test_sel  <= next_test_sel;
            digits    <= next_digits;
            test_run  <= next_test_run;
            view_slot <= next_view_slot;
            unit0     <= next_unit0;
            unit1     <= next_unit1;
            unit2     <= next_unit2;
        end
    end

    // Circular write pointers
    always_comb
    begin
        next_status_wp = status_push ? status_wp + 3'h1 : status_wp;
        next_fault_wp  = fault_push ? fault_wp + 3'h1 : fault_wp;
    end

    // Log storage; one write carries all simultaneous fault bits
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            status_wp <= 3'h0;
            fault_wp  <= 3'h0;
            for (int i = 0; i < dsl_pkg::LOG_DEPTH; i++)
            begin
                status_log[i] <= 8'h0;
                fault_log[i]  <= 8'h0;
            end
        end
        else
        begin
            status_wp <= next_status_wp;
            fault_wp  <= next_fault_wp;
            if (status_push)
                status_log[status_wp] <= hwdata[7:0];
            if (fault_push)
                fault_log[fault_wp] <= {1'b0, hwdata[dsl_pkg::FLT_UNUSED-1:0]};
        end
    end

    // Lamps and display
    always_comb
    begin
        next_lamps = '{addr: 4'h0, ready: 1'b1, fault: 1'b0, wprot: 1'b0};
        next_disp  = '{view: dsl_pkg::VIEW_STATUS, newest: 1'b0, slot: view_slot,
                       code: 8'h0, unit0: 8'h0, unit1: 8'h0, unit2: 8'h0};
        case (post)
            dsl_pkg::POST_RUN:  next_lamps = '{addr: 4'hf, ready: 1'b1, fault: 1'b1, wprot: 1'b1};
            dsl_pkg::POST_FAIL: next_lamps = '{addr: fail_code, ready: 1'b1, fault: 1'b1,
                                               wprot: 1'b0};
            default:            next_lamps.ready = 1'b1;
        endcase
        if (panel_fail)
            next_disp.view = dsl_pkg::VIEW_PANEL_FAIL;
        else if (diag == dsl_pkg::DIAG_SELECT)
        begin
            next_disp.view = dsl_pkg::VIEW_SELECT;
            next_disp.code = test_sel;
        end
        else if (diag == dsl_pkg::DIAG_RUN)
        begin
            case (test_run)
                dsl_pkg::TEST_STATUS_LOG:
                begin
                    next_disp.view   = dsl_pkg::VIEW_STATUS_LOG;
                    next_disp.code   = status_log[view_slot];
                    next_disp.newest = (view_slot == status_wp - 3'h1);
                end
                dsl_pkg::TEST_FAULT_LOG:
                begin
                    next_disp.view   = dsl_pkg::VIEW_FAULT_LOG;
                    next_disp.code   = fault_log[view_slot];
                    next_disp.newest = (view_slot == fault_wp - 3'h1);
                end
                dsl_pkg::TEST_UNITS:
                begin
                    next_disp.view  = dsl_pkg::VIEW_UNITS;
                    next_disp.unit0 = unit0;
                    next_disp.unit1 = unit1;
                    next_disp.unit2 = unit2;
                end
                default:
                begin
                    next_disp.view = dsl_pkg::VIEW_TEST_BUSY; // Tests run by firmware
                    next_disp.code = test_run;
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            lamps      <= '{addr: 4'hf, ready: 1'b1, fault: 1'b1, wprot: 1'b1};
            disp       <= '0;
            host_io_en <= 1'b0;
        end
        else
        begin
            lamps      <= next_lamps;
            disp       <= next_disp;
            host_io_en <= (post == dsl_pkg::POST_PASS) && (next_diag == dsl_pkg::DIAG_OFF);
        end
    end

    // Checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_post_lamps_lit: assert property (post == dsl_pkg::POST_RUN |=> lamps.fault && lamps.wprot)
        else $error("Lamps not lit during self-test");
    a_pass_fault_off: assert property ($rose(post == dsl_pkg::POST_PASS)
                                       |=> !lamps.fault && lamps.ready)
        else $error("Fault lamp not cleared after pass");
    a_fail_lamps_held: assert property (post == dsl_pkg::POST_FAIL ##1 post == dsl_pkg::POST_FAIL
                                        |-> lamps.ready && lamps.fault)
        else $error("Ready and fault lamps not held on failure");
    // Lowest set flag wins over higher ones
    a_fail_code_shown: assert property (post == dsl_pkg::POST_FAIL && fail_flags[2:0] == 3'h4
                                        |=> lamps.addr == 4'hd)
        else $error("Address lamps miss first failing test");
    // Enable is registered from next state, so it tracks diag in the same cycle
    a_host_io_cut: assert property (diag != dsl_pkg::DIAG_OFF |-> !host_io_en)
        else $error("Host I/O enabled in diagnostic mode");
    a_run_ends_test: assert property (diag == dsl_pkg::DIAG_RUN && press.run && !press.mode
                                      |=> diag == dsl_pkg::DIAG_SELECT && digits == 2'h0)
        else $error("Run key did not end test");
    a_log_ptr_wrap: assert property (status_push |=> status_wp == $past(status_wp) + 3'h1
                                     && status_log[$past(status_wp)] == $past(hwdata[7:0]))
        else $error("Status log write wrong");
    a_fault_bit7_clear: assert property (fault_push
                                         |=> fault_log[$past(fault_wp)][dsl_pkg::FLT_UNUSED] == 1'b0)
        else $error("Unused fault bit stored");
    a_step_advance: assert property (diag == dsl_pkg::DIAG_RUN && press.step && !press.run
                                     && !press.mode |=> view_slot == $past(view_slot) + 3'h1)
        else $error("Step key did not advance slot");
    a_newest_marked: assert property (disp.view == dsl_pkg::VIEW_STATUS_LOG
                                      && disp.slot == status_wp - 3'h1 && $stable(status_wp)
                                      && $stable(disp.slot) |-> disp.newest)
        else $error("Newest slot not marked");

    c_post_pass:   cover property (post == dsl_pkg::POST_RUN ##1 post == dsl_pkg::POST_PASS);
    c_post_fail:   cover property (post == dsl_pkg::POST_RUN ##1 post == dsl_pkg::POST_FAIL);
    c_test_run:    cover property (diag == dsl_pkg::DIAG_SELECT ##1 diag == dsl_pkg::DIAG_RUN);
    c_log_wrap:    cover property (status_push && status_wp == 3'h7);
    c_units_shown: cover property (disp.view == dsl_pkg::VIEW_UNITS);
endmodule
`default_nettype wire

/* test/dsl_panel.sv */
/* Operator panel model: presses keypad keys and hex digits.
   Assumes the logger synchronises the pins and acts on rising edges. */
`timescale 1ns/1ps
`default_nettype none
module dsl_panel (
    input  wire logic          hclk,
    output dsl_pkg::dsl_keys_t keys
);
    initial keys = '0;
    // Four clocks held and four released, above the three the logger needs
    task automatic press(input int k, input logic [3:0] d);
    begin
        keys.hex <= d;
        repeat (4) @(posedge hclk);
        keys[k] <= 1'b1;
        repeat (4) @(posedge hclk);
        keys[k] <= 1'b0;
        repeat (4) @(posedge hclk);
    end
    endtask
    // Two digits, high nibble first, then run
    task automatic select(input logic [7:0] t);
    begin
        press(4, t[7:4]);
        press(4, t[3:0]);
        press(6, 4'h0);
    end
    endtask
endmodule
`default_nettype wire

/* test/tb_top.sv */
/* Self-checking bench for the diagnostic logger: bus tasks and scenarios.
   Assumes a zero-wait AHB-Lite slave and a shortened self-test period. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, hresp, host_io_en;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
    logic [1:0] htrans = '0;
    logic [2:0] hsize = '0;
    dsl_pkg::dsl_keys_t keys;
    dsl_pkg::dsl_lamps_t lamps;
    dsl_pkg::dsl_disp_t disp;
    int n_errors = 0, samples_checked = 0;
    initial forever #2.5 hclk = ~hclk;
    dsl_top #(.POST_CYCLES(20)) dsl_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .keys_pin(keys), .lamps(lamps),
        .disp(disp), .host_io_en(host_io_en));
    dsl_panel dsl_panel_inst (.hclk(hclk), .keys(keys));
    task automatic final_report;
    begin
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    end
    endtask
    task automatic check(input string what, input logic [63:0] got, input logic [63:0] exp);
    begin
        samples_checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    end
    endtask
    // Bounded wait for hready at a rising edge
    task automatic wait_rdy;
        int n;
    begin
        n = 0;
        do
        begin
            @(posedge hclk);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 100);
        if (hreadyout !== 1'b1)
        begin
            n_errors++;
            final_report;
        end
    end
    endtask
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    begin
        hsel <= 1;
        haddr <= {24'h0, a};
        htrans <= dsl_pkg::HTRANS_NONSEQ;
        hwrite <= w;
        hsize <= dsl_pkg::HSIZE_WORD;
        wait_rdy;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy;
        rd = hrdata;
        check("hresp", hresp, 1'b0);
        hsel <= 0;
        // One idle edge so a following call never re-raises select in this step
        @(posedge hclk);
    end
    endtask
    task automatic post_pass;
    begin
        check("lamps run", lamps, 7'h7f);
        ahb(1, dsl_pkg::ADDR_POST_RESULT, 32'h0);
        repeat (30) @(posedge hclk);
        check("fault lamp", lamps.fault, 1'b0);
        ahb(0, dsl_pkg::ADDR_STATE, 32'h0);
        check("post state", rd[1:0], 2'h1);
        ahb(0, 8'h20, 32'h0);
        check("unmapped", rd, 32'h0);
    end
    endtask
    // Nine pushes wrap the pointer, so slot 0 holds the newest code
    task automatic logs;
    begin
        for (int i = 1; i <= 9; i++)
            ahb(1, dsl_pkg::ADDR_STATUS_PUSH, i);
        dsl_panel_inst.press(7, 4'h0);
        check("host io", host_io_en, 1'b0);
        dsl_panel_inst.select(8'h00);
        check("slot0", {disp.view, disp.newest, disp.slot, disp.code},
              {3'd3, 1'b1, 3'd0, 8'h09});
        dsl_panel_inst.press(5, 4'h0);
        check("slot1", {disp.newest, disp.slot, disp.code}, {1'b0, 3'd1, 8'h02});
        dsl_panel_inst.press(6, 4'h0);
        check("view", disp.view, 3'd2);
        ahb(1, dsl_pkg::ADDR_FAULT_PUSH, 32'hff);
        dsl_panel_inst.select(8'h01);
        check("fault", {disp.view, disp.code}, {3'd4, 8'h7f});
        dsl_panel_inst.press(6, 4'h0);
        dsl_panel_inst.select(8'h04);
        check("units", {disp.unit0, disp.unit1, disp.unit2}, 24'h030102);
        // A test run by firmware shows its number; mode then leaves from run
        dsl_panel_inst.press(6, 4'h0);
        dsl_panel_inst.select(8'h3a);
        check("busy", {disp.view, disp.code}, {3'd6, 8'h3a});
        dsl_panel_inst.press(7, 4'h0);
        check("host io on", host_io_en, 1'b1);
    end
    endtask
    // Two failing flags: the lower index wins, panel failure also flagged
    task automatic post_fail;
    begin
        hresetn <= 0;
        repeat (2) @(posedge hclk);
        hresetn <= 1;
        ahb(1, dsl_pkg::ADDR_POST_RESULT, 32'h10c);
        repeat (30) @(posedge hclk);
        check("fail lamps", {lamps.addr, lamps.ready, lamps.fault}, 6'h37);
        check("panel fail", disp.view, 3'd1);
    end
    endtask
    initial
    begin
        repeat (6) @(posedge hclk);
        hresetn <= 1;
        @(posedge hclk);
        post_pass;
        logs;
        post_fail;
        final_report;
    end
endmodule
`default_nettype wire
